// File: rtl/csfr_pkg.sv
// Function
// - any instruction may target the status register like a normal data register
// - flag-updating instructions block data writes to zero, nibble and carry bits (code: AND blocks only zero, rotates only nibble and carry)
// - timeout and powerdown bits ignore instruction writes
// - clear_file_instr on status clears bank bits, sets zero, keeps others
// - indirect_bank_select picks banks 2-3 when set, banks 0-1 when clear
// - direct_bank_select picks bank 0..3 for direct accesses
// - timeout flag set by power-up, watchdog clear and halt
// - timeout flag cleared when the watchdog timer expires
// - sleep flag set by power-up and watchdog clear
// - sleep flag cleared by halt
// - zero flag reflects a zero operation result
// - add and subtract set nibble carry from bit 3 carry-out
// - add and subtract set carry from the top result bit carry-out
// - for subtraction, carry flags mean no borrow when set
// - subtraction adds the two's complement of the second operand
// - rotates load carry with the bit shifted out
package csfr_pkg;
  localparam int unsigned BIT_CARRY  = 0;
  localparam int unsigned BIT_NIBBLE = 1;
  localparam int unsigned BIT_ZERO   = 2;
  localparam int unsigned BIT_SLEEP  = 3;
  localparam int unsigned BIT_TMO    = 4;
  localparam int unsigned BIT_DBS_LO = 5;
  localparam int unsigned BIT_IBS    = 7;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  // byte addresses of the AXI register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_OP     = 4'h4;
  localparam logic [3:0] ADDR_IRQST  = 4'h8;
  localparam logic [3:0] ADDR_IRQMSK = 4'hC;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // operation codes written into the op register
  typedef enum logic [3:0] {
    CSFR_OP_NONE = 4'h0, CSFR_OP_MOVE  = 4'h1, CSFR_OP_CLR  = 4'h2,
    CSFR_OP_ADD  = 4'h3, CSFR_OP_SUB   = 4'h4, CSFR_OP_AND  = 4'h5,
    CSFR_OP_RRF  = 4'h6, CSFR_OP_RLF   = 4'h7, CSFR_OP_WDTC = 4'h8,
    CSFR_OP_HALT = 4'h9, CSFR_OP_WDTO  = 4'hA
  } csfr_op_t;
  typedef struct packed {
    logic [7:0] res;
    logic       z;
    logic       dc;
    logic       c;
    logic       upd_z;
    logic       upd_dcc;
  } csfr_alu_t;
  typedef struct packed {
    logic [1:0] dbs;
    logic       ibs;
  } csfr_bank_t;
endpackage

// File: rtl/csfr_alu.sv
`timescale 1ns/1ps
module csfr_alu
  import csfr_pkg::*;
(
  input  wire csfr_op_t   op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       c_in,
  output csfr_alu_t       out
);
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    out = '0;
    sum = '0;
    nib = '0;
    case (op)
      CSFR_OP_ADD, CSFR_OP_SUB: begin
        // subtraction as a + ~b + 1; carry out then means no borrow
        sum = {1'b0, a} + {1'b0, (op == CSFR_OP_SUB) ? ~b : b}
            + {8'h00, op == CSFR_OP_SUB};
        nib = {1'b0, a[3:0]} + {1'b0, (op == CSFR_OP_SUB) ? ~b[3:0] : b[3:0]}
            + {4'h0, op == CSFR_OP_SUB};
        out.res = sum[7:0];
        out.c = sum[8];
        out.dc = nib[4];
        out.z = (sum[7:0] == ZERO_BYTE);
        out.upd_z = 1'b1;
        out.upd_dcc = 1'b1;
      end
      CSFR_OP_AND: begin
        out.res = a & b;
        out.z = ((a & b) == ZERO_BYTE);
        out.upd_z = 1'b1;
      end
      CSFR_OP_RRF: begin
        out.res = {c_in, a[7:1]};
        out.c = a[0];
        out.dc = 1'b0;
      end
      CSFR_OP_RLF: begin
        out.res = {a[6:0], c_in};
        out.c = a[7];
      end
      CSFR_OP_MOVE: out.res = b;
      default: out = '0;
    endcase
  end
endmodule

// File: rtl/csfr_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module csfr_top
  import csfr_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [1:0]       DIRECT_BANK,
  output logic             INDIRECT_BANK,
  output logic [7:0]       RESULT,
  output logic             IRQ
);
  logic [7:0]  status_r;
  logic [7:0]  result_r;
  logic [2:0]  irq_st_r;
  logic [2:0]  irq_msk_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        wr_fire;
  logic        rd_fire;
  logic        op_go;
  csfr_op_t    op_code;
  logic [7:0]  op_operand;
  logic        op_to_status;
  csfr_alu_t   alu_o;
  logic [7:0]  status_nxt;
  logic [2:0]  ev;
  csfr_bank_t  bank;

  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == ADDR_STATUS) || (a == ADDR_OP) || (a == ADDR_IRQST) || (a == ADDR_IRQMSK);
  endfunction

  // op register: [3:0] code, [15:8] operand, [16] destination is status
  assign op_code      = csfr_op_t'(wdata_r[3:0]);
  assign op_operand   = wdata_r[15:8];
  assign op_to_status = wdata_r[16];
  assign wr_fire      = aw_got_r && w_got_r && !bvalid_r;
  assign op_go        = wr_fire && (awaddr_r == ADDR_OP) && wstrb0_r;
  assign rd_fire      = S_AXI_ARVALID && S_AXI_ARREADY;

  csfr_alu u_alu (
    .op   (op_code),
    .a    (status_r),
    .b    (op_operand),
    .c_in (status_r[BIT_CARRY]),
    .out  (alu_o)
  );

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_got_r <= 1'b0;
      awaddr_r <= '0;
    end else if (S_AXI_AWVALID && !aw_got_r) begin
      aw_got_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_got_r  <= 1'b0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else if (S_AXI_WVALID && !w_got_r) begin
      w_got_r  <= 1'b1;
      wdata_r  <= S_AXI_WDATA;
      wstrb0_r <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = !aw_got_r;
  assign S_AXI_WREADY  = !w_got_r;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_DECERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // next status: direct store, then flag logic overrides, then events
  always_comb begin
    status_nxt = status_r;
    if (wr_fire && (awaddr_r == ADDR_STATUS) && wstrb0_r) begin
      status_nxt[BIT_IBS:BIT_DBS_LO] = wdata_r[BIT_IBS:BIT_DBS_LO];
      status_nxt[BIT_ZERO:BIT_CARRY] = wdata_r[BIT_ZERO:BIT_CARRY];
    end
    if (op_go) begin
      case (op_code)
        CSFR_OP_CLR: begin
          if (op_to_status) begin
            status_nxt[BIT_IBS:BIT_DBS_LO] = 3'h0;
          end
          status_nxt[BIT_ZERO] = 1'b1;
        end
        CSFR_OP_WDTC: begin
          status_nxt[BIT_TMO]   = 1'b1;
          status_nxt[BIT_SLEEP] = 1'b1;
        end
        CSFR_OP_HALT: begin
          status_nxt[BIT_TMO]   = 1'b1;
          status_nxt[BIT_SLEEP] = 1'b0;
        end
        CSFR_OP_WDTO: status_nxt[BIT_TMO] = 1'b0;
        default: begin
          if (op_to_status) begin
            // bank bits always take data; a flag bit takes data only when the op does not update it (rotates keep nibble, load carry with the bit shifted out)
            status_nxt[BIT_IBS:BIT_DBS_LO] = alu_o.res[BIT_IBS:BIT_DBS_LO];
            if (!alu_o.upd_z) begin
              status_nxt[BIT_ZERO] = alu_o.res[BIT_ZERO];
            end
            if (!alu_o.upd_dcc && op_code != CSFR_OP_RRF && op_code != CSFR_OP_RLF) begin
              status_nxt[BIT_NIBBLE:BIT_CARRY] = alu_o.res[BIT_NIBBLE:BIT_CARRY];
            end
          end
          if (alu_o.upd_z) begin
            status_nxt[BIT_ZERO] = alu_o.z;
          end
          if (alu_o.upd_dcc) begin
            status_nxt[BIT_NIBBLE] = alu_o.dc;
            status_nxt[BIT_CARRY]  = alu_o.c;
          end
          if (op_code == CSFR_OP_RRF || op_code == CSFR_OP_RLF) begin
            status_nxt[BIT_CARRY] = alu_o.c;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result_r <= '0;
    end else if (op_go) begin
      result_r <= alu_o.res;
    end
  end

  // events: 0 watchdog expiry, 1 halt entered, 2 zero result
  assign ev[0] = op_go && (op_code == CSFR_OP_WDTO);
  assign ev[1] = op_go && (op_code == CSFR_OP_HALT);
  assign ev[2] = op_go && alu_o.upd_z && alu_o.z;

  // set wins over the read clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= ((rd_fire && S_AXI_ARADDR == ADDR_IRQST) ? 3'h0 : irq_st_r) | ev;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_msk_r <= '0;
    end else if (wr_fire && (awaddr_r == ADDR_IRQMSK) && wstrb0_r) begin
      irq_msk_r <= wdata_r[2:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_DECERR;
      case (S_AXI_ARADDR)
        ADDR_STATUS: rdata_r <= {24'h000000, status_r};
        ADDR_OP:     rdata_r <= {24'h000000, result_r};
        ADDR_IRQST:  rdata_r <= {29'h0, irq_st_r};
        ADDR_IRQMSK: rdata_r <= {29'h0, irq_msk_r};
        default:     rdata_r <= '0;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  assign bank = '{dbs: status_r[BIT_DBS_LO+1:BIT_DBS_LO], ibs: status_r[BIT_IBS]};
  assign DIRECT_BANK   = bank.dbs;
  assign INDIRECT_BANK = bank.ibs;
  assign RESULT        = result_r;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_st_r & irq_msk_r);
    end
  end

  AST_CLR_STATUS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_CLR && op_to_status |=>
    status_r[BIT_IBS:BIT_DBS_LO] == 3'h0 && status_r[BIT_ZERO]
    && status_r[BIT_TMO] == $past(status_r[BIT_TMO]))
    else $error("clear of status wrong");
  AST_RO_BITS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_fire && awaddr_r == ADDR_STATUS |=> $stable(status_r[BIT_TMO:BIT_SLEEP]))
    else $error("read-only bits changed");
  AST_WDTC: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_WDTC |=> status_r[BIT_TMO] && status_r[BIT_SLEEP])
    else $error("watchdog clear flags wrong");
  AST_WDTO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_WDTO |=> !status_r[BIT_TMO])
    else $error("timeout flag not cleared");
  AST_HALT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_HALT |=> status_r[BIT_TMO] && !status_r[BIT_SLEEP])
    else $error("halt flags wrong");
  AST_ADD_C: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_ADD |=>
    status_r[BIT_CARRY] == ({1'b0, $past(status_r)} + {1'b0, $past(op_operand)} > 9'h0FF))
    else $error("add carry wrong");
  AST_SUB_C: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && op_code == CSFR_OP_SUB |=>
    status_r[BIT_CARRY] == ($past(status_r) >= $past(op_operand)))
    else $error("subtract borrow wrong");
  AST_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    op_go && alu_o.upd_z |=> status_r[BIT_ZERO] == (result_r == ZERO_BYTE))
    else $error("zero flag wrong");
  AST_IRQ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    |(irq_st_r & irq_msk_r) |=> IRQ)
    else $error("irq not raised");
  COV_ADD: cover property (@(posedge REF_CLK) disable iff (!RST_N) op_go && op_code == CSFR_OP_ADD);
  COV_HALT: cover property (@(posedge REF_CLK) disable iff (!RST_N) op_go && op_code == CSFR_OP_HALT);
  COV_IRQ: cover property (@(posedge REF_CLK) disable iff (!RST_N) IRQ);
endmodule

// File: dv/csfr_tb.sv
`timescale 1ns/1ps
module tb;
  import csfr_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  awaddr, araddr, wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, ind_bank, irq;
  logic [1:0]  bresp, rresp, dir_bank, resp;
  logic [7:0]  result;
  logic [31:0] rd_val;
  int          mismatches, comparisons, cycles;

  csfr_top i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DIRECT_BANK(dir_bank),
    .INDIRECT_BANK(ind_bank), .RESULT(result), .IRQ(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hung handshake ends the run here rather than inside a task
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // write address and data are offered together and dropped as each is taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    axi_rd(a, rd_val, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, what);
    chk(rd_val, {24'h0, exp}, what);
  endtask

  task automatic st_wr(input logic [7:0] v);
    axi_wr(ADDR_STATUS, {24'h0, v}, 4'hF, resp);
  endtask

  task automatic op_run(input csfr_op_t op, input logic [7:0] b, input logic dest);
    axi_wr(ADDR_OP, {15'h0, dest, b, 4'h0, op}, 4'hF, resp);
  endtask

  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 8'h18, "status reset");
    chk({29'h0, ind_bank, dir_bank, irq}, 32'h0, "pins reset");
    for (int i = 0; i < 8; i++) begin
      st_wr({i[2:0], 5'h00});
      rd_chk(ADDR_STATUS, {i[2:0], 5'h18}, "status write");
      chk({29'h0, ind_bank, dir_bank}, i, "bank pins");
    end
    st_wr(8'hE3);
    op_run(CSFR_OP_CLR, 8'h00, 1'b1);
    rd_chk(ADDR_STATUS, 8'h1F, "clear status");
    chk({30'h0, dir_bank}, 32'h0, "clear bank");
    st_wr(8'h00);
    op_run(CSFR_OP_ADD, 8'hE8, 1'b0);
    rd_chk(ADDR_STATUS, 8'h1F, "add flags");
    rd_chk(ADDR_OP, 8'h00, "add result");
    // borrow from the top bit only, then from the low nibble only
    op_run(CSFR_OP_SUB, 8'h20, 1'b0);
    rd_chk(ADDR_STATUS, 8'h1A, "sub borrow");
    chk({24'h0, result}, 32'hFF, "sub result");
    op_run(CSFR_OP_SUB, 8'h0F, 1'b0);
    rd_chk(ADDR_STATUS, 8'h19, "sub nibble borrow");
    chk({24'h0, result}, 32'h0B, "sub result");
    st_wr(8'h00);
    op_run(CSFR_OP_ADD, 8'h48, 1'b1);
    rd_chk(ADDR_STATUS, 8'h7A, "add to status");
    chk({29'h0, ind_bank, dir_bank}, 32'h3, "add bank");
    op_run(CSFR_OP_MOVE, 8'hE5, 1'b1);
    rd_chk(ADDR_STATUS, 8'hFD, "move to status");
    st_wr(8'h19);
    op_run(CSFR_OP_RRF, 8'h00, 1'b0);
    rd_chk(ADDR_STATUS, 8'h19, "rotate right");
    chk({24'h0, result}, 32'h8C, "rrf result");
    op_run(CSFR_OP_RLF, 8'h00, 1'b0);
    rd_chk(ADDR_STATUS, 8'h18, "rotate left");
    chk({24'h0, result}, 32'h33, "rlf result");
    axi_wr(ADDR_IRQMSK, 32'h0, 4'hF, resp);
    axi_rd(ADDR_IRQST, rd_val, resp);
    op_run(CSFR_OP_HALT, 8'h00, 1'b0);
    rd_chk(ADDR_STATUS, 8'h10, "halt");
    chk({31'h0, irq}, 32'h0, "irq masked");
    axi_wr(ADDR_IRQMSK, 32'h2, 4'hF, resp);
    rd_chk(ADDR_IRQMSK, 8'h02, "mask readback");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(ADDR_IRQST, 8'h02, "halt event");
    rd_chk(ADDR_IRQST, 8'h00, "event cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    op_run(CSFR_OP_WDTO, 8'h00, 1'b0);
    rd_chk(ADDR_STATUS, 8'h00, "watchdog expiry");
    rd_chk(ADDR_IRQST, 8'h01, "expiry event");
    op_run(CSFR_OP_WDTC, 8'h00, 1'b0);
    rd_chk(ADDR_STATUS, 8'h18, "watchdog clear");
    axi_rd(4'h2, rd_val, resp);
    chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped read resp");
    chk(rd_val, 32'h0, "unmapped read data");
    axi_wr(4'h6, 32'hFF, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped write resp");
    axi_wr(ADDR_STATUS, 32'hE0, 4'h0, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "no strobe resp");
    rd_chk(ADDR_STATUS, 8'h18, "no strobe write");
    stop_test();
  end
endmodule
